//--- design/lmr_params.svh
`ifndef LMR_PARAMS_SVH
`define LMR_PARAMS_SVH

// Register map (byte addresses)
`define LMR_ADDR_WIDTH 8
`define LMR_ADDR_CTRL0 8'h00
`define LMR_ADDR_CTRL1 8'h04
`define LMR_ADDR_STATUS 8'h08
`define LMR_ADDR_DOT_FIRST 8'h10
`define LMR_ADDR_DOT_LAST 8'h20

// Brightness word fields
`define LMR_CTRL0_WIDTH 7
`define LMR_CTRL0_RESET 7'h00
`define LMR_PWM_LSB 0
`define LMR_PEAK_LSB 4
`define LMR_SLEEP_BIT 6

// Clock control word fields
`define LMR_CTRL1_WIDTH 2
`define LMR_CTRL1_RESET 2'h0
`define LMR_EXTSEL_BIT 0
`define LMR_PRESCALE_BIT 1

// Matrix and scan timing, in display clock cycles
`define LMR_ROWS 8
`define LMR_COLS 20
`define LMR_DOT_WORDS 5
`define LMR_SCAN_CYCLES 512
`define LMR_SLOT_CYCLES 64
`define LMR_BLANK_CYCLES 4
`define LMR_MAX_ON 60
`define LMR_PRESCALE_DIV 8

// Internal oscillator, derived from the system clock
`define LMR_CLK_HZ 50000000
`define LMR_INT_OSC_HZ 200000
`define LMR_INT_OSC_DIV (`LMR_CLK_HZ / `LMR_INT_OSC_HZ)

`endif

//--- design/lmr_pkg.sv
`default_nettype none
package lmr_pkg;

	typedef enum logic [1:0] {
		PEAK_73 = 2'b00,
		PEAK_50 = 2'b01,
		PEAK_31 = 2'b10,
		PEAK_100 = 2'b11
	} lmr_peak_type;

	typedef enum logic [1:0] {
		PH_SLEEP = 2'b00,
		PH_ON = 2'b01,
		PH_OFF = 2'b10,
		PH_BLANK = 2'b11
	} lmr_phase_type;

endpackage
`default_nettype wire

//--- design/lmr_pwm_table.sv
`include "lmr_params.svh"
`default_nettype none
module lmr_pwm_table (
	input wire logic [3:0] code,
	output logic [5:0] onCycles
);

	// Brightness code to on-cycles per row slot
	always_comb
	begin
		case (code)
			4'h0: onCycles = 6'd0;
			4'h1: onCycles = 6'd1;
			4'h2: onCycles = 6'd2;
			4'h3: onCycles = 6'd3;
			4'h4: onCycles = 6'd4;
			4'h5: onCycles = 6'd5;
			4'h6: onCycles = 6'd7;
			4'h7: onCycles = 6'd9;
			4'h8: onCycles = 6'd11;
			4'h9: onCycles = 6'd14;
			4'ha: onCycles = 6'd18;
			4'hb: onCycles = 6'd22;
			4'hc: onCycles = 6'd28;
			4'hd: onCycles = 6'd36;
			4'he: onCycles = 6'd48;
			default: onCycles = 6'(`LMR_MAX_ON);
		endcase
	end

endmodule
`default_nettype wire

//--- design/lmr_disp_clock.sv
`include "lmr_params.svh"
`default_nettype none
module lmr_disp_clock #(
	parameter int INT_DIV = `LMR_INT_OSC_DIV
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic oscIn,
	input wire logic useExternal,
	input wire logic prescale,
	input wire logic awake,
	output logic displayTick
);

	localparam int W = (INT_DIV < 2) ? 1 : $clog2(INT_DIV);
	localparam logic [W-1:0] INT_LAST = W'(INT_DIV - 1);
	localparam logic [2:0] PRE_LAST = 3'(`LMR_PRESCALE_DIV - 1);

	logic oscMeta;
	logic oscSync;
	logic oscLast;
	logic extEdge;
	logic [2:0] preCount;
	logic [W-1:0] intCount;

	if (INT_DIV < 2)
	begin : g_bad_div
		$error("INT_DIV must be at least 2");
	end

	// Two-stage synchroniser for the oscillator pin
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			oscMeta <= 1'b0;
			oscSync <= 1'b0;
			oscLast <= 1'b0;
		end
		else
		begin
			oscMeta <= oscIn;
			oscSync <= oscMeta;
			oscLast <= oscSync;
		end
	end

	assign extEdge = oscSync & ~oscLast;

	// Internal oscillator stops while asleep
	always_ff @(posedge clk)
	begin
		if (reset || !awake || useExternal)
			intCount <= '0;
		else if (intCount == INT_LAST)
			intCount <= '0;
		else
			intCount <= intCount + 1'b1;
	end

	// Divide-by-eight prescaler for the external source
	always_ff @(posedge clk)
	begin
		if (reset || !useExternal)
			preCount <= '0;
		else if (extEdge)
			preCount <= preCount + 1'b1;
	end

	// Display clock source select
	always_ff @(posedge clk)
	begin
		if (reset)
			displayTick <= 1'b0;
		else if (useExternal)
			displayTick <= extEdge && (!prescale || preCount == PRE_LAST);
		else
			displayTick <= awake && intCount == INT_LAST;
	end

	prescale_pass_a: assert property (@(posedge clk) disable iff (reset)
		useExternal && !prescale && extEdge |=> displayTick)
		else $error("external edge without prescaler gave no tick");

	prescale_hold_a: assert property (@(posedge clk) disable iff (reset)
		useExternal && prescale && extEdge && preCount != PRE_LAST
		|=> !displayTick)
		else $error("prescaler passed an early edge");

	cover_prescaled_c: cover property (@(posedge clk) disable iff (reset)
		useExternal && prescale && displayTick);

endmodule
`default_nettype wire

//--- design/lmr_refresh_pwm.sv
`include "lmr_params.svh"
`default_nettype none
module lmr_refresh_pwm #(
	parameter int INT_DIV = `LMR_INT_OSC_DIV
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [`LMR_ADDR_WIDTH-1:0] address,
	input wire logic [31:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [31:0] readData,
	input wire logic oscIn,
	output logic [`LMR_ROWS-1:0] rowEnable,
	output logic [`LMR_COLS-1:0] columnDrive,
	output logic [1:0] peakCurrent
);

	localparam int DOT_BITS = `LMR_ROWS * `LMR_COLS;

	logic [`LMR_CTRL0_WIDTH-1:0] brightWord;
	logic [`LMR_CTRL1_WIDTH-1:0] clockWord;
	logic [31:0] dotWord [0:`LMR_DOT_WORDS-1];
	logic [DOT_BITS-1:0] dotFlat;
	logic [8:0] scanCount;
	logic [2:0] row;
	logic [5:0] slot;
	logic [5:0] onTime;
	logic awake;
	logic displayTick;
	logic dotHit;
	logic [2:0] dotIndex;
	lmr_pkg::lmr_phase_type phase;
	lmr_pkg::lmr_phase_type next_phase;
	logic [8:0] tickCount;

	if (DOT_BITS != `LMR_DOT_WORDS * 32)
	begin : g_bad_store
		$error("dot store size mismatch");
	end

	assign row = scanCount[8:6];
	assign slot = scanCount[5:0];
	assign awake = brightWord[`LMR_SLEEP_BIT];

	assign dotHit = address >= `LMR_ADDR_DOT_FIRST &&
		address <= `LMR_ADDR_DOT_LAST && address[1:0] == 2'h0;
	assign dotIndex = 3'((address - `LMR_ADDR_DOT_FIRST) >> 2);

	// Control words
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			brightWord <= `LMR_CTRL0_RESET;
			clockWord <= `LMR_CTRL1_RESET;
		end
		else if (writeStrobe)
		begin
			if (address == `LMR_ADDR_CTRL0)
				brightWord <= writeData[`LMR_CTRL0_WIDTH-1:0];
			else if (address == `LMR_ADDR_CTRL1)
				clockWord <= writeData[`LMR_CTRL1_WIDTH-1:0];
		end
	end

	// Dot store, five words, row r holds bits r*20 upward
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < `LMR_DOT_WORDS; i++)
				dotWord[i] <= 32'h0;
		end
		else if (writeStrobe && dotHit)
			dotWord[dotIndex] <= writeData;
	end

	for (genvar w = 0; w < `LMR_DOT_WORDS; w++)
	begin : g_flat
		assign dotFlat[w*32 +: 32] = dotWord[w];
	end

	// Read port, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset || !readStrobe)
			readData <= 32'h0;
		else if (address == `LMR_ADDR_CTRL0)
			readData <= {25'h0, brightWord};
		else if (address == `LMR_ADDR_CTRL1)
			readData <= {30'h0, clockWord};
		else if (address == `LMR_ADDR_STATUS)
			readData <= {21'h0, phase, row, slot};
		else if (dotHit)
			readData <= dotWord[dotIndex];
		else
			readData <= 32'h0;
	end

	lmr_disp_clock #(
		.INT_DIV(INT_DIV)
	) u_clock (
		.clk(clk),
		.reset(reset),
		.oscIn(oscIn),
		.useExternal(clockWord[`LMR_EXTSEL_BIT]),
		.prescale(clockWord[`LMR_PRESCALE_BIT]),
		.awake(awake),
		.displayTick(displayTick)
	);

	lmr_pwm_table u_table (
		.code(brightWord[`LMR_PWM_LSB +: 4]),
		.onCycles(onTime)
	);

	// Scan counter: row in upper bits, slot position in lower six
	always_ff @(posedge clk)
	begin
		if (reset)
			scanCount <= 9'h0;
		else if (displayTick && awake)
			scanCount <= scanCount + 9'h1;
	end

	// Phase of the current slot
	always_comb
	begin
		if (!awake)
			next_phase = lmr_pkg::PH_SLEEP;
		else if (slot >= 6'(`LMR_MAX_ON))
			next_phase = lmr_pkg::PH_BLANK;
		else if (slot < onTime)
			next_phase = lmr_pkg::PH_ON;
		else
			next_phase = lmr_pkg::PH_OFF;
	end

	// Row and column drivers, registered
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			phase <= lmr_pkg::PH_SLEEP;
			rowEnable <= '0;
			columnDrive <= '0;
		end
		else
		begin
			phase <= next_phase;
			case (next_phase)
				lmr_pkg::PH_ON:
				begin
					rowEnable <= `LMR_ROWS'(1) << row;
					columnDrive <= dotFlat[row*`LMR_COLS +: `LMR_COLS];
				end
				default:
				begin
					rowEnable <= '0;
					columnDrive <= '0;
				end
			endcase
		end
	end

	// Peak current code follows the brightness word
	always_ff @(posedge clk)
	begin
		if (reset)
			peakCurrent <= lmr_pkg::PEAK_73;
		else
			peakCurrent <= brightWord[`LMR_PEAK_LSB +: 2];
	end

	// Helper: display ticks since the last scan wrap
	always_ff @(posedge clk)
	begin
		if (reset)
			tickCount <= 9'h0;
		else if (displayTick && awake)
			tickCount <= (scanCount == 9'h1ff) ? 9'h0 : tickCount + 9'h1;
	end

	rows_onehot_a: assert property (@(posedge clk) disable iff (reset)
		$onehot0(rowEnable))
		else $error("more than one row enabled");

	scan_length_a: assert property (@(posedge clk) disable iff (reset)
		displayTick && awake && scanCount == 9'h1ff
		|-> tickCount == 9'h1ff ##1 scanCount == 9'h0)
		else $error("scan did not take 512 display clocks");

	slot_change_a: assert property (@(posedge clk) disable iff (reset)
		row != $past(row) |-> $past(slot) == 6'h3f)
		else $error("row changed before its slot ended");

	blank_gap_a: assert property (@(posedge clk) disable iff (reset)
		slot >= 6'd60 |=> rowEnable == '0 && columnDrive == '0)
		else $error("pixels lit in the blanking gap");

	on_limit_a: assert property (@(posedge clk) disable iff (reset)
		rowEnable != '0 |-> $past(slot) < $past(onTime) &&
		$past(onTime) <= 6'd60)
		else $error("row lit beyond its on-time");

	row_match_a: assert property (@(posedge clk) disable iff (reset)
		rowEnable != '0 |-> rowEnable == (8'h01 << $past(row)) &&
		columnDrive == $past(dotFlat[row*20 +: 20]))
		else $error("columns not from the active row");

	sleep_blank_a: assert property (@(posedge clk) disable iff (reset)
		!awake ##1 !awake |-> rowEnable == '0 && columnDrive == '0 &&
		$stable(scanCount) &&
		(clockWord[`LMR_EXTSEL_BIT] || !displayTick))
		else $error("display not blanked in sleep");

	word_example_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && address == `LMR_ADDR_CTRL0 &&
		writeData[6:0] == 7'b1001101
		|=> onTime == 6'd36 ##1 peakCurrent == 2'b00)
		else $error("example word decoded wrongly");

	row_wrap_a: assert property (@(posedge clk) disable iff (reset)
		displayTick && awake && scanCount == 9'h1ff |=> row == 3'h0)
		else $error("row did not wrap to the first");

	slot_start_a: assert property (@(posedge clk) disable iff (reset)
		awake && slot == 6'h0 && onTime != 6'h0 ##1 awake && slot == 6'h0
		|-> rowEnable != '0)
		else $error("on-time did not start at slot start");

	peak_follow_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && address == `LMR_ADDR_CTRL0
		|-> ##2 peakCurrent == $past(writeData[`LMR_PEAK_LSB +: 2], 2))
		else $error("peak current not taken from the word");

	pwm_top_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && address == `LMR_ADDR_CTRL0 &&
		writeData[`LMR_PWM_LSB +: 4] == 4'hf |=> onTime == 6'h3c)
		else $error("top code did not give 60 on-cycles");

	pwm_zero_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && address == `LMR_ADDR_CTRL0 &&
		writeData[`LMR_PWM_LSB +: 4] == 4'h0 |=> onTime == 6'h0)
		else $error("code zero gave on-cycles");

	column_dark_a: assert property (@(posedge clk) disable iff (reset)
		rowEnable == '0 |-> columnDrive == '0)
		else $error("columns driven with no row enabled");

	read_idle_a: assert property (@(posedge clk) disable iff (reset)
		!readStrobe |=> readData == 32'h0)
		else $error("read data stood without a read");

	scan_step_a: assert property (@(posedge clk) disable iff (reset)
		scanCount == $past(scanCount) +
		{8'h0, $past(displayTick && awake)})
		else $error("scan counter skipped or moved without a tick");

	row_step_a: assert property (@(posedge clk) disable iff (reset)
		row != $past(row) |-> row == $past(row) + 3'h1)
		else $error("rows not scanned in turn");

	dot_write_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && dotHit
		|=> dotWord[$past(dotIndex)] == $past(writeData))
		else $error("dot word not stored");

	sleep_status_a: assert property (@(posedge clk) disable iff (reset)
		readStrobe && address == `LMR_ADDR_STATUS &&
		!awake && !$past(awake)
		|=> readData[10:9] == 2'h0)
		else $error("status did not show sleep");

	cover_wrap_c: cover property (@(posedge clk) disable iff (reset)
		displayTick && awake && scanCount == 9'h1ff);

	cover_full_on_c: cover property (@(posedge clk) disable iff (reset)
		phase == lmr_pkg::PH_ON && slot == 6'd59);

	cover_sleep_c: cover property (@(posedge clk) disable iff (reset)
		awake ##1 !awake);

	cover_external_c: cover property (@(posedge clk) disable iff (reset)
		clockWord[`LMR_EXTSEL_BIT] && displayTick);

endmodule
`default_nettype wire

//--- testbench/lmr_matrix_model.sv
`default_nettype none
module lmr_matrix_model (
	input wire logic clk,
	input wire logic clear,
	input wire logic [7:0] rowEnable,
	input wire logic [19:0] columnDrive,
	input wire logic [159:0] dots,
	output logic [15:0] litClocks,
	output logic [7:0] faults
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] prevRow;
	logic [19:0] expCols;
	logic bad;
	always_comb
	begin
		expCols = 20'h0;
		for (int r = 0; r < 8; r++)
			if (rowEnable[r])
				expCols = dots[20*r +: 20];
	end
	// Sinks see one row at a time, next row in turn
	assign bad = !$onehot0(rowEnable) || columnDrive != expCols
		|| (rowEnable != 8'h0 && prevRow != 8'h0 && rowEnable != prevRow
		&& rowEnable != {prevRow[6:0], prevRow[7]});
	always_ff @(posedge clk)
	begin
		if (clear)
		begin
			litClocks <= 16'h0;
			faults <= 8'h0;
			prevRow <= 8'h0;
		end
		else
		begin
			if (rowEnable != 8'h0)
				litClocks <= litClocks + 16'h1;
			if (rowEnable != 8'h0)
				prevRow <= rowEnable;
			if (bad)
				faults <= faults + 8'h1;
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 2;
	logic clk, reset, writeStrobe, readStrobe, oscIn, oscRun, clear;
	logic [7:0] address, rowEnable, faults;
	logic [31:0] writeData, readData, rdVal;
	logic [19:0] columnDrive;
	logic [1:0] peakCurrent;
	logic [15:0] litClocks;
	logic [159:0] dots;
	int oscCnt, oscHalf;
	int err_count, comparisons, n, m;
	int onTab[16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22, 28, 36, 48, 60};
	lmr_refresh_pwm #(.INT_DIV(DIV)) u_dut (.clk(clk), .reset(reset),
		.address(address), .writeData(writeData), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .readData(readData), .oscIn(oscIn),
		.rowEnable(rowEnable), .columnDrive(columnDrive),
		.peakCurrent(peakCurrent));
	lmr_matrix_model u_model (.clk(clk), .clear(clear), .rowEnable(rowEnable),
		.columnDrive(columnDrive), .dots(dots), .litClocks(litClocks),
		.faults(faults));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// External oscillator: 1 MHz direct, 6.25 MHz behind the prescaler
	always @(posedge clk)
	begin
		if (oscCnt >= oscHalf - 1)
		begin
			oscCnt <= 0;
			oscIn <= oscRun & ~oscIn;
		end
		else
			oscCnt <= oscCnt + 1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clk);
		readStrobe <= 1'b0;
		#1;
		rdVal = readData;
	endtask
	// Lit clocks over one window after the setting has settled
	task automatic lit(input int win, input int exp);
		repeat (win + 8) @(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (win) @(posedge clk);
		#1;
		check(litClocks, exp);
		check(faults, 32'h0);
	endtask
	task automatic waitRise(input int b, output int k);
		k = 0;
		for (int s = 0; s < 2; s++)
			while (rowEnable[b] !== s[0] && k < 5000)
			begin
				@(posedge clk);
				#1;
				k++;
			end
		if (k >= 5000)
		begin
			err_count++;
			$display("ERROR t=%0t row wait timed out", $time);
			give_verdict();
		end
	endtask
	initial
	begin
		reset = 1'b1;
		address = 8'h00;
		writeData = 32'h0;
		writeStrobe = 1'b0;
		readStrobe = 1'b0;
		oscIn = 1'b0;
		oscRun = 1'b0;
		clear = 1'b0;
		oscCnt = 0;
		oscHalf = 25;
		err_count = 0;
		comparisons = 0;
		for (int k = 0; k < 5; k++)
			dots[32*k +: 32] = 32'h1357_9bdf + k * 32'h2468_ace1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(8'h00);
		check(rdVal, 32'h0);
		check({rowEnable, columnDrive, peakCurrent}, 32'h0);
		wr(8'h0c, 32'h7f);
		rd(8'h0c);
		check(rdVal, 32'h0);
		rd(8'h00);
		check(rdVal, 32'h0);
		rd(8'h04);
		check(rdVal, 32'h0);
		for (int k = 0; k < 5; k++)
			wr(8'h10 + 8'(4 * k), dots[32*k +: 32]);
		$display("reset and map test done");
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h00, 32'h40 | c);
			rd(8'h00);
			check(rdVal, 32'h40 | c);
			lit(64 * DIV, onTab[c] * DIV);
		end
		$display("pwm test done");
		for (int p = 0; p < 4; p++)
		begin
			wr(8'h00, 32'h4f | (p << 4));
			repeat (3) @(posedge clk);
			#1;
			check(peakCurrent, p);
		end
		waitRise(0, n);
		waitRise(1, n);
		waitRise(0, m);
		check(n, 64 * DIV);
		check(n + m, 512 * DIV);
		$display("peak and scan test done");
		wr(8'h00, 32'h0f);
		lit(64 * DIV, 0);
		rd(8'h08);
		check(rdVal[10:9], 2'h0);
		$display("sleep test done");
		wr(8'h00, 32'h4f);
		wr(8'h04, 32'h1);
		oscRun <= 1'b1;
		lit(3200, 3000);
		oscHalf <= 4;
		wr(8'h04, 32'h3);
		lit(4096, 3840);
		rd(8'h04);
		check(rdVal, 32'h3);
		$display("external clock test done");
		give_verdict();
	end
endmodule
`default_nettype wire
